// ---- common/spi_eeprom_pkg.sv ----
// Constants, opcodes, status layout and state type of the serial nonvolatile memory
package spi_eeprom_pkg;

    // Array geometry
    localparam int ADDR_W = 12;
    localparam int DEPTH = 4096;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W = 5;
    localparam int BYTE_W = 8;

    // Instruction opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;

    // Status byte field positions
    localparam int STAT_PPE_BIT = 7;
    localparam int STAT_BPH_BIT = 3;
    localparam int STAT_BPL_BIT = 2;
    localparam int STAT_WEL_BIT = 1;
    localparam int STAT_WIP_BIT = 0;
    localparam logic [7:0] STATUS_BUSY_VALUE = 8'hff;

    // Reset values of the protection bits
    localparam logic PPE_RESET = 1'b0;
    localparam logic [1:0] BP_RESET = 2'b00;
    localparam logic WEL_RESET = 1'b0;

    // Block-protect codes and protected range bases
    localparam logic [1:0] BP_NONE = 2'b00;
    localparam logic [1:0] BP_QUARTER = 2'b01;
    localparam logic [1:0] BP_HALF = 2'b10;
    localparam logic [1:0] BP_ALL = 2'b11;
    localparam logic [11:0] PROT_QUARTER_BASE = 12'hc00;
    localparam logic [11:0] PROT_HALF_BASE = 12'h800;

    // Self-timed write cycle
    localparam int CLK_FREQ_MHZ = 50;
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_FREQ_MHZ;
    localparam int TIMER_W = 24;

    // Pin synchroniser width
    localparam int PIN_COUNT = 5;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_READ,
        ST_WRITE,
        ST_STAT_RD,
        ST_STAT_WR,
        ST_IGNORE
    } state_t;

endpackage

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 5
) (
    // Clock and control
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Pins
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta_q;
            logic stable_q;
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    meta_q <= 1'b1;
                    stable_q <= 1'b1;
                end
                else if (ce_i)
                begin
                    meta_q <= async_i[g];
                    stable_q <= meta_q;
                end
            end
            assign sync_o[g] = stable_q;
        end
    endgenerate

endmodule // pin_sync

// ---- src/spi_eeprom_core.sv ----
// Command decoder, status byte, protection and array of the serial nonvolatile memory
// How it works
// RULE1 - Input bits taken on rising link clock, output changes after falling edge.
// RULE2 - Deselected: output released to high impedance, standby unless a write runs.
// RULE3 - After reset nothing happens until a falling chip select is seen.
// RULE4 - Pin low with enable bit set refuses status writes; all else works.
// RULE5 - Pin falling while selected aborts a pending status write; running ones continue.
// RULE6 - Enable bit zero makes the protect pin ignored entirely.
// RULE7 - Host may pause a selected transfer with pause low, clock low.
// RULE8 - Paused: inputs ignored; after release the command continues where it stood.
// RULE9 - Eight-bit instruction register; everything moves most significant bit first.
// RULE10 - First bit on first rising clock after select; clock may stop anywhere.
// RULE11 - Writes complete only with latch set; set and clear commands drive it.
// RULE12 - Latch cleared at reset and after every completed write cycle.
// RULE13 - Status read answered at any time, even during a write.
// RULE14 - Status: enable bit 7, zeros 6..4, protect pair 3..2, latch 1, busy 0.
// RULE15 - Only enable and protect pair are writable; latch and busy are device-owned.
// RULE16 - Busy reads one during a write and every other bit reads one.
// RULE17 - Protect pair: none, top quarter, top half, whole array.
// RULE18 - Protected bytes read normally; writes to them leave contents unchanged.
// RULE19 - Opcodes 06 set latch, 04 clear latch, 05 read status.
// RULE20 - Opcodes 01 write status, 03 read, 02 write of one to 32 bytes.
// RULE21 - Hardware protection = pin low and enable set; blocks status writes.
// RULE22 - Under hardware protection the enable bit cannot be cleared.
// RULE23 - Sixteen address bits follow; only the low twelve select a byte.
// RULE24 - Reads auto-increment and wrap from the top location to zero.
// RULE25 - Page writes wrap inside their 32-byte page, overwriting earlier bytes.
// RULE26 - Write starts only if select rises right after a whole data byte.
// RULE27 - Write duration is a cycle-count parameter; busy stays high until it ends.
`timescale 1ns/10ps
module spi_eeprom_core #(
    parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES
) (
    // Clock, reset, enable
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // Serial link pins
    input wire logic SCK_I,
    input wire logic SI_I,
    input wire logic CS_N_I,
    input wire logic HOLD_N_I,
    input wire logic WP_N_I,
    output logic SO_O,
    output logic SO_OE_O,
    // Power state
    output logic STANDBY_O
);

    localparam int AW = spi_eeprom_pkg::ADDR_W;
    localparam int PB = spi_eeprom_pkg::PAGE_BYTES;
    localparam int PW = spi_eeprom_pkg::PAGE_W;
    localparam int TW = spi_eeprom_pkg::TIMER_W;

    // Synchronised pins
    logic [spi_eeprom_pkg::PIN_COUNT-1:0] pins_s;
    logic sck_s;
    logic si_s;
    logic cs_n_s;
    logic hold_n_s;
    logic wp_n_s;

    pin_sync #(
        .WIDTH(spi_eeprom_pkg::PIN_COUNT)
    ) u_pin_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .async_i({WP_N_I, HOLD_N_I, CS_N_I, SI_I, SCK_I}),
        .sync_o(pins_s)
    );

    assign sck_s = pins_s[0];
    assign si_s = pins_s[1];
    assign cs_n_s = pins_s[2];
    assign hold_n_s = pins_s[3];
    assign wp_n_s = pins_s[4];

    // State
    spi_eeprom_pkg::state_t state_q;
    spi_eeprom_pkg::state_t state_d;
    logic sck_prev_q;
    logic cs_prev_q;
    logic wp_prev_q;
    logic [2:0] bitcnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic so_q;
    logic so_oe_q;
    logic standby_q;
    logic [AW-1:0] addr_q;
    logic addr_hi_done_q;
    logic op_read_q;
    logic [7:0] pbuf_q [PB];
    logic [PB-1:0] pvalid_q;
    logic wr_have_q;
    logic [AW-PW-1:0] page_q;
    logic [7:0] stat_new_q;
    logic stat_have_q;
    logic stat_abort_q;
    logic ppe_q;
    logic [1:0] bp_q;
    logic wel_q;
    logic [TW-1:0] timer_q;
    logic commit_arr_q;
    logic commit_stat_q;
    logic [7:0] mem [spi_eeprom_pkg::DEPTH];

    // Edge detection and decode
    wire selected = ~cs_n_s;
    wire sck_rise = selected & hold_n_s & sck_s & ~sck_prev_q; // RULE1 RULE7 RULE8
    wire sck_fall = selected & hold_n_s & ~sck_s & sck_prev_q; // RULE1 RULE8
    wire cs_fall = cs_prev_q & ~cs_n_s; // RULE3
    wire cs_rise = ~cs_prev_q & cs_n_s;
    wire wp_fall = wp_prev_q & ~wp_n_s;
    wire in_frame = (state_q != spi_eeprom_pkg::ST_IDLE);
    wire bit_take = sck_rise & in_frame; // RULE10
    wire [7:0] shift_d = {shift_q[6:0], si_s}; // RULE9
    wire byte_done = bit_take & (bitcnt_q == 3'h7);
    wire write_in_progress = (timer_q != '0); // RULE27
    wire timer_end = (timer_q == TW'(1));
    wire hw_prot = ppe_q & ~wp_n_s; // RULE6 RULE21
    wire on_boundary = (bitcnt_q == 3'h0); // RULE26
    wire cmd_byte = byte_done & (state_q == spi_eeprom_pkg::ST_CMD);
    wire [7:0] status_view = write_in_progress ? spi_eeprom_pkg::STATUS_BUSY_VALUE // RULE16
        : {ppe_q, 3'h0, bp_q, wel_q, 1'b0}; // RULE14
    wire [AW-1:0] addr_next = AW'(addr_q + 12'h001); // RULE24
    wire [AW-1:0] rd_addr = (state_q == spi_eeprom_pkg::ST_ADDR) ?
        {addr_q[11:8], shift_d} : addr_next;
    wire [7:0] rd_data = mem[rd_addr]; // RULE18
    wire addr_last = byte_done & (state_q == spi_eeprom_pkg::ST_ADDR) & addr_hi_done_q;
    wire start_arr = cs_rise & (state_q == spi_eeprom_pkg::ST_WRITE) & wr_have_q
        & on_boundary & wel_q & ~write_in_progress; // RULE11 RULE26
    wire start_stat = cs_rise & (state_q == spi_eeprom_pkg::ST_STAT_WR) & stat_have_q
        & on_boundary & wel_q & ~write_in_progress & ~hw_prot & ~stat_abort_q; // RULE4 RULE21 RULE22
    wire tx_active = (state_q == spi_eeprom_pkg::ST_READ)
        | (state_q == spi_eeprom_pkg::ST_STAT_RD);

    function automatic logic is_protected(input logic [11:0] a, input logic [1:0] bp);
        case (bp)
            spi_eeprom_pkg::BP_QUARTER: is_protected = (a >= spi_eeprom_pkg::PROT_QUARTER_BASE);
            spi_eeprom_pkg::BP_HALF: is_protected = (a >= spi_eeprom_pkg::PROT_HALF_BASE);
            spi_eeprom_pkg::BP_ALL: is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase // RULE17
    endfunction

    // Next state
    always_comb
    begin
        state_d = state_q;
        if (cs_fall)
        begin
            state_d = spi_eeprom_pkg::ST_CMD;
        end
        else if (cs_rise)
        begin
            state_d = spi_eeprom_pkg::ST_IDLE; // RULE2
        end
        else if (byte_done)
        begin
            case (state_q)
                spi_eeprom_pkg::ST_CMD:
                begin
                    if (shift_d == spi_eeprom_pkg::OP_READ_STATUS)
                        state_d = spi_eeprom_pkg::ST_STAT_RD; // RULE13 RULE19
                    else if (write_in_progress)
                        state_d = spi_eeprom_pkg::ST_IGNORE;
                    else if (shift_d == spi_eeprom_pkg::OP_WRITE_STATUS)
                        state_d = spi_eeprom_pkg::ST_STAT_WR; // RULE20
                    else if ((shift_d == spi_eeprom_pkg::OP_READ)
                             || (shift_d == spi_eeprom_pkg::OP_WRITE))
                        state_d = spi_eeprom_pkg::ST_ADDR; // RULE20
                    else
                        state_d = spi_eeprom_pkg::ST_IGNORE;
                end
                spi_eeprom_pkg::ST_ADDR:
                begin
                    if (addr_hi_done_q)
                        state_d = op_read_q ? spi_eeprom_pkg::ST_READ
                            : spi_eeprom_pkg::ST_WRITE; // RULE23
                end
                default: state_d = state_q;
            endcase
        end
    end

    // Frame state, edges and bit counter
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            state_q <= spi_eeprom_pkg::ST_IDLE; // RULE3
            sck_prev_q <= 1'b1;
            cs_prev_q <= 1'b1;
            wp_prev_q <= 1'b1;
            bitcnt_q <= 3'h0;
            shift_q <= 8'h00;
        end
        else if (CE_I)
        begin
            state_q <= state_d;
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_n_s;
            wp_prev_q <= wp_n_s;
            if (cs_fall)
                bitcnt_q <= 3'h0;
            else if (bit_take)
                bitcnt_q <= bitcnt_q + 3'h1; // RULE10
            if (bit_take)
                shift_q <= shift_d; // RULE9
        end
    end

    // Address and opcode capture
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            addr_q <= '0;
            addr_hi_done_q <= 1'b0;
            op_read_q <= 1'b0;
        end
        else if (CE_I)
        begin
            if (cmd_byte)
            begin
                addr_hi_done_q <= 1'b0;
                op_read_q <= (shift_d == spi_eeprom_pkg::OP_READ);
            end
            if (byte_done && state_q == spi_eeprom_pkg::ST_ADDR)
            begin
                addr_hi_done_q <= 1'b1;
                if (!addr_hi_done_q)
                    addr_q[11:8] <= shift_d[3:0]; // RULE23
                else
                    addr_q[7:0] <= shift_d;
            end
            else if (byte_done && state_q == spi_eeprom_pkg::ST_READ)
                addr_q <= addr_next; // RULE24
            else if (byte_done && state_q == spi_eeprom_pkg::ST_WRITE)
                addr_q[PW-1:0] <= PW'(addr_q[PW-1:0] + 5'h01); // RULE25
        end
    end

    // Serial output path
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            tx_q <= 8'h00;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            standby_q <= 1'b1;
        end
        else if (CE_I)
        begin
            if ((cmd_byte && shift_d == spi_eeprom_pkg::OP_READ_STATUS)
                || (byte_done && state_q == spi_eeprom_pkg::ST_STAT_RD))
                tx_q <= status_view; // RULE13
            else if ((addr_last && op_read_q)
                     || (byte_done && state_q == spi_eeprom_pkg::ST_READ))
                tx_q <= rd_data; // RULE18 RULE24
            else if (sck_fall && tx_active)
                tx_q <= {tx_q[6:0], 1'b0}; // RULE9
            if (sck_fall && tx_active)
                so_q <= tx_q[7]; // RULE1
            so_oe_q <= selected & hold_n_s & tx_active; // RULE2
            standby_q <= cs_n_s & ~write_in_progress & ~start_arr & ~start_stat; // RULE2
        end
    end

    // Page buffer and status byte capture
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            pvalid_q <= '0;
            wr_have_q <= 1'b0;
            stat_new_q <= 8'h00;
            stat_have_q <= 1'b0;
            stat_abort_q <= 1'b0;
        end
        else if (CE_I)
        begin
            if (cmd_byte && !write_in_progress)
            begin
                pvalid_q <= '0;
                wr_have_q <= 1'b0;
                stat_have_q <= 1'b0;
            end
            else if (byte_done && state_q == spi_eeprom_pkg::ST_WRITE)
            begin
                pvalid_q[addr_q[PW-1:0]] <= 1'b1; // RULE25
                wr_have_q <= 1'b1;
            end
            else if (byte_done && state_q == spi_eeprom_pkg::ST_STAT_WR && !stat_have_q)
            begin
                stat_new_q <= shift_d;
                stat_have_q <= 1'b1;
            end
            if (wp_fall && selected && ppe_q)
                stat_abort_q <= 1'b1; // RULE5 RULE6
            else if (cs_fall)
                stat_abort_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (CE_I && byte_done && state_q == spi_eeprom_pkg::ST_WRITE)
            pbuf_q[addr_q[PW-1:0]] <= shift_d; // RULE25
    end

    // Self-timed write cycle and protection bits
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            timer_q <= '0;
            commit_arr_q <= 1'b0;
            commit_stat_q <= 1'b0;
            page_q <= '0;
            ppe_q <= spi_eeprom_pkg::PPE_RESET;
            bp_q <= spi_eeprom_pkg::BP_RESET;
            wel_q <= spi_eeprom_pkg::WEL_RESET; // RULE12
        end
        else if (CE_I)
        begin
            if (start_arr || start_stat)
            begin
                timer_q <= TW'(WRITE_CYCLES); // RULE27
                commit_arr_q <= start_arr;
                commit_stat_q <= start_stat;
                page_q <= addr_q[AW-1:PW];
            end
            else if (write_in_progress)
                timer_q <= timer_q - TW'(1);
            if (write_in_progress && timer_end)
            begin
                wel_q <= 1'b0; // RULE12
                if (commit_stat_q)
                begin
                    ppe_q <= stat_new_q[spi_eeprom_pkg::STAT_PPE_BIT]; // RULE15
                    bp_q <= {stat_new_q[spi_eeprom_pkg::STAT_BPH_BIT],
                             stat_new_q[spi_eeprom_pkg::STAT_BPL_BIT]}; // RULE15
                end
            end
            else if (cmd_byte && !write_in_progress && shift_d == spi_eeprom_pkg::OP_SET_LATCH)
                wel_q <= 1'b1; // RULE11 RULE19
            else if (cmd_byte && !write_in_progress && shift_d == spi_eeprom_pkg::OP_CLEAR_LATCH)
                wel_q <= 1'b0; // RULE11 RULE19
        end
    end

    // Array commit at the end of the write cycle
    always_ff @(posedge CLK_I)
    begin
        if (CE_I && write_in_progress && timer_end && commit_arr_q)
        begin
            for (int i = 0; i < PB; i++)
            begin
                if (pvalid_q[i] && !is_protected({page_q, PW'(i)}, bp_q))
                    mem[{page_q, PW'(i)}] <= pbuf_q[i]; // RULE17 RULE18
            end
        end
    end

    assign SO_O = so_q;
    assign SO_OE_O = so_oe_q;
    assign STANDBY_O = standby_q;

endmodule // spi_eeprom_core

// ---- tb/spi_eeprom_props.sv ----
// Port-level assertions of the serial memory core
`timescale 1ns/10ps
module spi_eeprom_props #(
    parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // Link pins
    input wire logic SCK_I,
    input wire logic SI_I,
    input wire logic CS_N_I,
    input wire logic HOLD_N_I,
    input wire logic WP_N_I,
    // Outputs
    input wire logic SO_O,
    input wire logic SO_OE_O,
    input wire logic STANDBY_O
);
    localparam int IDLE_LIMIT = WRITE_CYCLES + 16;
    logic sck_q;
    logic [5:0] fall_q;
    logic [5:0] fall_d;
    logic [5:0] rise_q;
    logic [5:0] rise_d;
    int idle_q;
    int idle_d;
    assign fall_d = {fall_q[4:0], sck_q & ~SCK_I};
    assign rise_d = CS_N_I ? 6'h00 : rise_q + {5'h00, ~sck_q & SCK_I & HOLD_N_I & ~&rise_q};
    assign idle_d = !CS_N_I ? 0 : (idle_q > IDLE_LIMIT ? idle_q : idle_q + 1);
    always_ff @(posedge CLK_I)
    begin
        sck_q <= RST_N_I & SCK_I;
        fall_q <= RST_N_I ? fall_d : 6'h00;
        rise_q <= RST_N_I ? rise_d : 6'h00;
        idle_q <= RST_N_I ? idle_d : 0;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence desel_s;
        CS_N_I [*6];
    endsequence
    sequence sel_s;
        !CS_N_I [*6];
    endsequence
    sequence held_s;
        !HOLD_N_I [*6];
    endsequence
    so_release_a: assert property (desel_s |-> !SO_OE_O)
        else $error("output driven while deselected");
    select_active_a: assert property (sel_s |-> !STANDBY_O)
        else $error("standby while selected");
    hold_release_a: assert property (held_s |-> !SO_OE_O)
        else $error("output driven while paused");
    standby_cause_a: assert property ($fell(STANDBY_O) |-> !$past(CS_N_I, 3))
        else $error("active without select");
    oe_cause_a: assert property ($rose(SO_OE_O) |-> !STANDBY_O && rise_q >= 6'h08)
        else $error("output before opcode byte");
    so_edge_a: assert property ($changed(SO_O) && SO_OE_O && $past(SO_OE_O) |-> |fall_q)
        else $error("output changed away from falling clock");
    reset_quiet_a: assert property ($rose(RST_N_I) |-> STANDBY_O && !SO_OE_O && !SO_O)
        else $error("outputs not quiet after reset");
    idle_standby_a: assert property (idle_q > IDLE_LIMIT |-> STANDBY_O)
        else $error("no standby after write time");
endmodule // spi_eeprom_props

bind spi_eeprom_core spi_eeprom_props #(.WRITE_CYCLES(WRITE_CYCLES)) props_i (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .SCK_I(SCK_I), .SI_I(SI_I),
    .CS_N_I(CS_N_I), .HOLD_N_I(HOLD_N_I), .WP_N_I(WP_N_I), .SO_O(SO_O),
    .SO_OE_O(SO_OE_O), .STANDBY_O(STANDBY_O)
);

// ---- tb/spi_host_model.sv ----
// Behavioural serial host that frames commands for the memory core
`timescale 1ns/10ps
module spi_host_model (
    // Clock and returned data
    input wire logic clk_i,
    input wire logic so_i,
    input wire logic so_oe_i,
    // Link pins
    output logic sck_o,
    output logic si_o,
    output logic cs_n_o,
    output logic hold_n_o
);
    logic [39:0] tx;
    logic [39:0] rx;
    int hold_bit = -1;
    int drop_bits = 0;
    initial
    begin
        sck_o = 1'b0;
        si_o = 1'b1;
        cs_n_o = 1'b1;
        hold_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Sends n bytes of tx less drop_bits bits, most significant first, and captures rx
    task automatic frame(input int n);
        int k;
        cs_n_o <= 1'b0;
        tick(6);
        for (k = 0; k < 8 * n - drop_bits; k++)
        begin
            if (k == hold_bit)
            begin
                tick(2);
                hold_n_o <= 1'b0;
                tick(2);
                si_o <= ~si_o;
                sck_o <= 1'b1;
                tick(2);
                sck_o <= 1'b0;
                tick(2);
                hold_n_o <= 1'b1;
                tick(2);
            end
            si_o <= tx[39 - k];
            tick(4);
            sck_o <= 1'b1;
            tick(2);
            rx[39 - k] = so_oe_i ? so_i : 1'bz;
            tick(2);
            sck_o <= 1'b0;
        end
        tick(4);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        tick(8);
    endtask
endmodule // spi_host_model

// ---- tb/tb_top.sv ----
// Self-checking bench of the serial memory core
`timescale 1ns/10ps
module tb_top;
    localparam int WC = 300;
    typedef struct packed {
        logic wp;
        logic clr;
        logic [7:0] val;
        logic [7:0] exp;
    } row_t;
    logic clk;
    logic rst_n;
    logic wp_n;
    logic sck;
    logic si;
    logic cs_n;
    logic hold_n;
    logic so;
    logic so_oe;
    logic stby;
    int miscompares = 0;
    int n_tests = 0;
    row_t rows [6] = '{'{1'b1, 1'b0, 8'h8c, 8'h8c}, '{1'b0, 1'b1, 8'h00, 8'h8c},
        '{1'b1, 1'b0, 8'h04, 8'h04}, '{1'b0, 1'b0, 8'hff, 8'h8c},
        '{1'b0, 1'b1, 8'h84, 8'h8c}, '{1'b1, 1'b0, 8'h01, 8'h00}};

    spi_eeprom_core #(.WRITE_CYCLES(WC)) uut (
        .CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .SCK_I(sck), .SI_I(si),
        .CS_N_I(cs_n), .HOLD_N_I(hold_n), .WP_N_I(wp_n), .SO_O(so),
        .SO_OE_O(so_oe), .STANDBY_O(stby)
    );
    spi_host_model host (
        .clk_i(clk), .so_i(so), .so_oe_i(so_oe), .sck_o(sck), .si_o(si),
        .cs_n_o(cs_n), .hold_n_o(hold_n)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic go(input int n, input logic [39:0] t);
        host.tx = t;
        host.frame(n);
    endtask
    task automatic op(input logic [7:0] c);
        go(1, {c, 32'h0});
    endtask
    task automatic settle;
        repeat (WC + 20) @(posedge clk);
    endtask
    task automatic wr_stat(input logic [7:0] v);
        op(8'h06);
        go(2, {8'h01, v, 24'h0});
        settle();
    endtask
    task automatic chk_stat(input logic [7:0] e);
        go(2, 40'h0500000000);
        check(host.rx[31:24], e);
    endtask
    task automatic chk_rd(input logic [15:0] a, input logic [15:0] e, input int n);
        int i;
        go(5, {8'h03, a, 16'h0000});
        for (i = 0; i < n; i++)
            check(host.rx[15 - 8 * i -: 8], e[15 - 8 * i -: 8]);
    endtask

    initial
    begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check({7'h00, stby}, 8'h01);
        chk_stat(8'h00);
        op(8'h06);
        chk_stat(8'h02);
        op(8'h04);
        chk_stat(8'h00);
        foreach (rows[i])
        begin
            wp_n <= rows[i].wp;
            wr_stat(rows[i].val);
            if (rows[i].clr)
                op(8'h04);
            chk_stat(rows[i].exp);
        end
        host.hold_bit = 3;
        chk_stat(8'h00);
        host.hold_bit = -1;
        op(8'h06);
        go(4, 40'h02f000c300);
        chk_stat(8'hff);
        settle();
        chk_stat(8'h00);
        op(8'h06);
        go(5, 40'h02ffff5a3c);
        settle();
        chk_rd(16'h0fff, 16'h5ac3, 2);
        chk_rd(16'h0fe0, 16'h3c00, 1);
        wr_stat(8'h04);
        op(8'h06);
        go(4, 40'h020fff1100);
        settle();
        op(8'h06);
        go(4, 40'h0200002200);
        settle();
        chk_rd(16'h0fff, 16'h5a22, 2);
        host.hold_bit = 28;
        chk_rd(16'h0fff, 16'h5a22, 2);
        host.hold_bit = -1;
        wr_stat(8'h0c);
        op(8'h06);
        go(4, 40'h0200004400);
        settle();
        chk_rd(16'h0000, 16'h2200, 1);
        wr_stat(8'h00);
        op(8'h06);
        host.drop_bits = 3;
        go(4, 40'h0200005500);
        host.drop_bits = 0;
        op(8'h04);
        go(4, 40'h0200006600);
        settle();
        chk_rd(16'h0000, 16'h2200, 1);
        wr_stat(8'h80);
        op(8'h06);
        fork
            go(2, 40'h018c000000);
            begin
                repeat (40) @(posedge clk);
                wp_n <= 1'b0;
                repeat (20) @(posedge clk);
                wp_n <= 1'b1;
            end
        join
        wp_n <= 1'b1;
        settle();
        op(8'h04);
        chk_stat(8'h80);
        op(8'h06);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check({7'h00, stby}, 8'h01);
        chk_stat(8'h00);
        complete_run();
    end
endmodule // tb_top
